// file: rtl/dss_status_sequencer.sv
// Top of the drive state machine, status word and supply sequencing.
`timescale 1ns/1ps
`default_nettype none
module dss_status_sequencer
#(
    parameter int TICK_CYC = dss_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Commands from the fieldbus
    input wire logic [15:0] I_CTRL_WORD,
    input wire logic I_RESTART,
    input wire logic [1:0] I_TELEGRAM_SEL,
    // Configuration
    input wire logic [1:0] I_SUPPLY_MODE,
    input wire logic [dss_pkg::TIMEOUT_WIDTH-1:0] I_SUPPLY_WAIT_TIMEOUT,
    // Drive conditions
    input wire logic I_INIT_DONE,
    input wire logic I_POWER_PRESENT,
    input wire logic I_FAULT_DETECT,
    input wire logic I_FAULT_REACTION_DONE,
    input wire logic I_QSTOP_DONE,
    input wire logic I_WARNING,
    input wire logic I_DIRECTION_REV,
    input wire logic I_STOP_KEY,
    input wire logic I_INTERNAL_LIMIT,
    input wire logic I_TARGET_REACHED,
    input wire logic I_REMOTE,
    // Status
    output logic [15:0] O_STATUS_WORD,
    output logic [2:0] O_STATE,
    output logic O_AWAITING_SUPPLY_INDICATION,
    output logic O_CONTACTOR_SUPPLY_FAULT,
    output logic O_CONTACTOR_CLOSE,
    output logic [1:0] O_TELEGRAM_ACTIVE
);
    import dss_pkg::*;
    dss_link_if lnk();
    dss_state_e state;
    dss_state_e next_state;
    logic fr_prev;
    logic fault_reset_edge;
    logic cmd_shutdown, cmd_switch_on, cmd_enable, cmd_dis_voltage, cmd_qstop;
    logic timeout_event;
    logic fault_entry;
    logic qstop_history;
    logic load_pending;
    dss_status_pack u_pack
    (
        .lnk(lnk)
    );
    dss_supply_timer #(.TICK_CYC(TICK_CYC)) u_timer
    (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .lnk(lnk)
    );
    assign lnk.state = state;
    assign lnk.qstop_history = qstop_history;
    assign lnk.volt_present = I_POWER_PRESENT;
    assign lnk.warning = I_WARNING;
    assign lnk.dir_rev = I_DIRECTION_REV;
    assign lnk.stop_key = I_STOP_KEY;
    assign lnk.int_limit = I_INTERNAL_LIMIT;
    assign lnk.target = I_TARGET_REACHED;
    assign lnk.remote = I_REMOTE;
    assign lnk.timeout_ms = I_SUPPLY_WAIT_TIMEOUT;
    // The wait runs only while switched on without supply.
    assign lnk.timer_run = (state == ST_SWITCHED_ON) && !I_POWER_PRESENT;
    assign cmd_dis_voltage = !I_CTRL_WORD[CW_EN_VOLTAGE];
    assign cmd_qstop = I_CTRL_WORD[CW_EN_VOLTAGE] && !I_CTRL_WORD[CW_QSTOP];
    assign cmd_shutdown = I_CTRL_WORD[CW_EN_VOLTAGE] &&
        I_CTRL_WORD[CW_QSTOP] && !I_CTRL_WORD[CW_SWITCH_ON];
    assign cmd_switch_on = I_CTRL_WORD[CW_EN_VOLTAGE] &&
        I_CTRL_WORD[CW_QSTOP] && I_CTRL_WORD[CW_SWITCH_ON] &&
        !I_CTRL_WORD[CW_EN_OP];
    assign cmd_enable = I_CTRL_WORD[CW_EN_VOLTAGE] &&
        I_CTRL_WORD[CW_QSTOP] && I_CTRL_WORD[CW_SWITCH_ON] &&
        I_CTRL_WORD[CW_EN_OP];
    assign fault_reset_edge = I_CTRL_WORD[CW_FAULT_RESET] && !fr_prev;
    assign timeout_event = lnk.expired;
    assign fault_entry = (I_FAULT_DETECT || timeout_event) &&
        (state != ST_NOT_READY) && (state != ST_FAULT_REACT) &&
        (state != ST_FAULT);
    always_comb
    begin
        next_state = state;
        case (state)
            ST_NOT_READY:
            begin
                if (I_INIT_DONE)
                begin
                    next_state = ST_SW_ON_DIS;
                end
            end
            ST_SW_ON_DIS:
            begin
                if (cmd_shutdown)
                begin
                    next_state = ST_READY;
                end
            end
            ST_READY:
            begin
                if (cmd_dis_voltage || cmd_qstop)
                begin
                    next_state = ST_SW_ON_DIS;
                end
                else if (cmd_enable)
                begin
                    next_state = ST_OP_ENABLED;
                end
                else if (cmd_switch_on)
                begin
                    next_state = ST_SWITCHED_ON;
                end
            end
            ST_SWITCHED_ON:
            begin
                if (cmd_dis_voltage || cmd_qstop)
                begin
                    next_state = ST_SW_ON_DIS;
                end
                else if (cmd_shutdown)
                begin
                    next_state = ST_READY;
                end
                else if (cmd_enable && I_POWER_PRESENT)
                begin
                    next_state = ST_OP_ENABLED;
                end
            end
            ST_OP_ENABLED:
            begin
                if (cmd_dis_voltage)
                begin
                    next_state = ST_SW_ON_DIS;
                end
                else if (cmd_qstop)
                begin
                    next_state = ST_QSTOP;
                end
                else if (cmd_shutdown)
                begin
                    next_state = ST_READY;
                end
                else if (cmd_switch_on)
                begin
                    next_state = ST_SWITCHED_ON;
                end
            end
            ST_QSTOP:
            begin
                if (cmd_dis_voltage || I_QSTOP_DONE)
                begin
                    next_state = ST_SW_ON_DIS;
                end
            end
            ST_FAULT_REACT:
            begin
                if (I_FAULT_REACTION_DONE)
                begin
                    next_state = ST_FAULT;
                end
            end
            ST_FAULT:
            begin
                if (fault_reset_edge && !I_FAULT_DETECT)
                begin
                    next_state = ST_SW_ON_DIS;
                end
            end
            default:
            begin
                next_state = ST_NOT_READY;
            end
        endcase
        if (fault_entry)
        begin
            next_state = ST_FAULT_REACT;
        end
    end
    // A restart drops the drive back to its power-up state.
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state <= ST_NOT_READY;
        end
        else if (I_RESTART)
        begin
            state <= ST_NOT_READY;
        end
        else
        begin
            state <= next_state;
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            fr_prev <= 1'b0;
        end
        else
        begin
            fr_prev <= I_CTRL_WORD[CW_FAULT_RESET];
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            qstop_history <= 1'b0;
        end
        else if (fault_entry)
        begin
            qstop_history <= (state == ST_QSTOP);
        end
        else if (state != ST_FAULT_REACT && state != ST_FAULT)
        begin
            qstop_history <= 1'b0;
        end
    end
    // Set wins over the fault-reset clear in the same cycle.
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_CONTACTOR_SUPPLY_FAULT <= 1'b0;
        end
        else if (timeout_event && state == ST_SWITCHED_ON)
        begin
            O_CONTACTOR_SUPPLY_FAULT <= 1'b1;
        end
        else if (state == ST_FAULT && fault_reset_edge)
        begin
            O_CONTACTOR_SUPPLY_FAULT <= 1'b0;
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_CONTACTOR_CLOSE <= 1'b0;
        end
        else
        begin
            O_CONTACTOR_CLOSE <= (I_SUPPLY_MODE == MODE_CONTACTOR) &&
                ((next_state == ST_SWITCHED_ON) ||
                 (next_state == ST_OP_ENABLED) ||
                 (next_state == ST_QSTOP));
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_STATUS_WORD <= STATUS_RESET;
            O_AWAITING_SUPPLY_INDICATION <= 1'b0;
        end
        else
        begin
            O_STATUS_WORD <= lnk.next_word;
            O_AWAITING_SUPPLY_INDICATION <= (state == ST_READY) &&
                !I_POWER_PRESENT;
        end
    end
    assign O_STATE = state;
    // The selection is sampled once after reset and again only on restart.
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            load_pending <= 1'b1;
            O_TELEGRAM_ACTIVE <= TELEGRAM_RESET;
        end
        else if (load_pending || I_RESTART)
        begin
            load_pending <= 1'b0;
            O_TELEGRAM_ACTIVE <= I_TELEGRAM_SEL;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    property p_masked(dss_state_e st, logic [15:0] code);
        state == st |=> (O_STATUS_WORD & STATE_MASK) == code;
    endproperty
    AST_SOD_CODE: assert property (
        p_masked(ST_SW_ON_DIS, MASKED_SW_ON_DIS))
        else $error("Switch-on disabled code wrong.");
    AST_FREACT_CODE: assert property (
        p_masked(ST_FAULT_REACT, MASKED_FAULT_REACT))
        else $error("Fault reaction code wrong.");
    AST_FAULT_CODE: assert property (state == ST_FAULT |=>
        (O_STATUS_WORD & STATE_MASK) ==
        ($past(qstop_history) ? MASKED_FAULT_QS : MASKED_FAULT))
        else $error("Fault code wrong.");
    AST_NOT_READY: assert property (state == ST_NOT_READY |=>
        (O_STATUS_WORD & 16'h004F) == 16'h0000)
        else $error("Not ready flags not low.");
    AST_HIGH_BYTE: assert property (##1
        O_STATUS_WORD[SW_TARGET] == $past(I_TARGET_REACHED) &&
        O_STATUS_WORD[13:12] == 2'h0 && !O_STATUS_WORD[8])
        else $error("High byte wrong.");
    AST_READY_TO_OP: assert property (state == ST_READY &&
        cmd_enable && !fault_entry && !I_RESTART |=> state == ST_OP_ENABLED)
        else $error("Enable from ready not taken.");
    AST_READY_SUPPLY: assert property (state == ST_READY |=>
        (O_STATUS_WORD & READY_MASK) ==
        ($past(I_POWER_PRESENT) ? READY_SUPPLY : READY_NO_SUPPLY))
        else $error("Ready status with supply wrong.");
    AST_TIMEOUT_FAULT: assert property (state == ST_SWITCHED_ON &&
        lnk.expired && !I_RESTART
        |=> state == ST_FAULT_REACT && O_CONTACTOR_SUPPLY_FAULT)
        else $error("Supply timeout did not fault.");
    AST_CONTACTOR_OPEN: assert property (
        (next_state == ST_READY || next_state == ST_SW_ON_DIS)
        |=> !O_CONTACTOR_CLOSE)
        else $error("Contactor closed before switch on.");
    AST_CONTACTOR_CLOSE: assert property (
        I_SUPPLY_MODE == MODE_CONTACTOR && state == ST_READY &&
        cmd_switch_on && !fault_entry && !I_RESTART |=> O_CONTACTOR_CLOSE)
        else $error("Switch on did not close contactor.");
    AST_TELEGRAM_HOLD: assert property (
        !load_pending && !I_RESTART |=> $stable(O_TELEGRAM_ACTIVE))
        else $error("Telegram changed without restart.");
    COV_REACH_OP: cover property (state == ST_READY ##1 state == ST_OP_ENABLED);
    COV_TIMEOUT: cover property (state == ST_SWITCHED_ON ##1
        state == ST_FAULT_REACT);
    COV_QS_FAULT: cover property (state == ST_FAULT && qstop_history);
endmodule
`default_nettype wire

// file: rtl/dss_pkg.sv
// Constants, types and state codes for the drive state status sequencer.
// Summary of operation
// - High byte: direction 15, stop key 14, limit 11, target 10, remote 9.
// - Fault reaction: fault, qstop, enabled, switched on, ready set; masked 002F.
// - Fault state shows only fault, 0008; after quick stop also qstop, 0028.
// - Not ready state holds fault, enabled, switched on, ready, disabled low.
// - From ready, enable operation goes directly to operation enabled.
// - Separate supply: ready reads 21 hex without and 31 hex with supply.
// - Supply still absent in switched on at timeout raises contactor fault.
// - Contactor mode: switch on closes the contactor and applies supply.
// - Contactor mode: contactor stays open through shutdown and ready.
// - A new cyclic telegram selection takes effect only after restart.
package dss_pkg;
    typedef enum logic [2:0]
    {
        ST_NOT_READY = 3'b000,
        ST_SW_ON_DIS = 3'b001,
        ST_READY = 3'b010,
        ST_SWITCHED_ON = 3'b011,
        ST_OP_ENABLED = 3'b100,
        ST_QSTOP = 3'b101,
        ST_FAULT_REACT = 3'b110,
        ST_FAULT = 3'b111
    } dss_state_e;
    localparam int SW_READY = 0;
    localparam int SW_SWITCHED_ON = 1;
    localparam int SW_OP_ENABLED = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_VOLTAGE = 4;
    localparam int SW_QSTOP = 5;
    localparam int SW_SW_ON_DIS = 6;
    localparam int SW_WARNING = 7;
    localparam int SW_REMOTE = 9;
    localparam int SW_TARGET = 10;
    localparam int SW_LIMIT = 11;
    localparam int SW_STOP_KEY = 14;
    localparam int SW_DIRECTION = 15;
    localparam int CW_SWITCH_ON = 0;
    localparam int CW_EN_VOLTAGE = 1;
    localparam int CW_QSTOP = 2;
    localparam int CW_EN_OP = 3;
    localparam int CW_FAULT_RESET = 7;
    localparam logic [15:0] STATE_MASK = 16'h006F;
    localparam logic [15:0] MASKED_SW_ON_DIS = 16'h0040;
    localparam logic [15:0] MASKED_READY = 16'h0021;
    localparam logic [15:0] MASKED_SWITCHED_ON = 16'h0023;
    localparam logic [15:0] MASKED_OP_ENABLED = 16'h0027;
    localparam logic [15:0] MASKED_QSTOP = 16'h0007;
    localparam logic [15:0] MASKED_FAULT_REACT = 16'h002F;
    localparam logic [15:0] MASKED_FAULT = 16'h0008;
    localparam logic [15:0] MASKED_FAULT_QS = 16'h0028;
    localparam logic [15:0] READY_MASK = 16'h007F;
    localparam logic [15:0] READY_NO_SUPPLY = 16'h0021;
    localparam logic [15:0] READY_SUPPLY = 16'h0031;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [1:0] MODE_COMBINED = 2'h0;
    localparam logic [1:0] MODE_SEPARATE = 2'h1;
    localparam logic [1:0] MODE_CONTACTOR = 2'h2;
    localparam logic [1:0] TELEGRAM_RESET = 2'h0;
    localparam int CLK_FREQ_MHZ = 250;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_MHZ * TICK_TIME_US;
    localparam int TIMEOUT_WIDTH = 16;
endpackage

// file: rtl/dss_link_if.sv
// Interface joining the sequencer core to its status packer and timer.
`timescale 1ns/1ps
`default_nettype none
interface dss_link_if;
    import dss_pkg::*;
    dss_state_e state;
    logic qstop_history;
    logic volt_present;
    logic warning;
    logic dir_rev;
    logic stop_key;
    logic int_limit;
    logic target;
    logic remote;
    logic [15:0] next_word;
    logic timer_run;
    logic [TIMEOUT_WIDTH-1:0] timeout_ms;
    logic expired;
    modport core
    (
        output state, qstop_history, volt_present, warning, dir_rev,
        output stop_key, int_limit, target, remote, timer_run, timeout_ms,
        input next_word, expired
    );
    modport pack
    (
        input state, qstop_history, volt_present, warning, dir_rev,
        input stop_key, int_limit, target, remote,
        output next_word
    );
    modport timer
    (
        input timer_run, timeout_ms,
        output expired
    );
endinterface
`default_nettype wire

// file: rtl/dss_status_pack.sv
// Combinational builder of the next status word from state and flags.
`timescale 1ns/1ps
`default_nettype none
module dss_status_pack
(
    dss_link_if.pack lnk
);
    import dss_pkg::*;
    always_comb
    begin
        lnk.next_word = STATUS_RESET;
        case (lnk.state)
            ST_NOT_READY:
            begin
                lnk.next_word = STATUS_RESET;
            end
            ST_SW_ON_DIS:
            begin
                lnk.next_word[SW_SW_ON_DIS] = 1'b1;
            end
            ST_READY:
            begin
                lnk.next_word[SW_QSTOP] = 1'b1;
                lnk.next_word[SW_READY] = 1'b1;
            end
            ST_SWITCHED_ON:
            begin
                lnk.next_word[SW_QSTOP] = 1'b1;
                lnk.next_word[SW_READY] = 1'b1;
                lnk.next_word[SW_SWITCHED_ON] = 1'b1;
            end
            ST_OP_ENABLED:
            begin
                lnk.next_word[SW_QSTOP] = 1'b1;
                lnk.next_word[SW_READY] = 1'b1;
                lnk.next_word[SW_SWITCHED_ON] = 1'b1;
                lnk.next_word[SW_OP_ENABLED] = 1'b1;
            end
            ST_QSTOP:
            begin
                lnk.next_word[SW_READY] = 1'b1;
                lnk.next_word[SW_SWITCHED_ON] = 1'b1;
                lnk.next_word[SW_OP_ENABLED] = 1'b1;
            end
            ST_FAULT_REACT:
            begin
                lnk.next_word[SW_QSTOP] = 1'b1;
                lnk.next_word[SW_FAULT] = 1'b1;
                lnk.next_word[SW_READY] = 1'b1;
                lnk.next_word[SW_SWITCHED_ON] = 1'b1;
                lnk.next_word[SW_OP_ENABLED] = 1'b1;
            end
            ST_FAULT:
            begin
                lnk.next_word[SW_FAULT] = 1'b1;
                lnk.next_word[SW_QSTOP] = lnk.qstop_history;
            end
            default:
            begin
                lnk.next_word = STATUS_RESET;
            end
        endcase
        // Voltage shows the real supply so a missing supply is visible.
        lnk.next_word[SW_VOLTAGE] = lnk.volt_present;
        lnk.next_word[SW_WARNING] = lnk.warning;
        lnk.next_word[SW_REMOTE] = lnk.remote;
        lnk.next_word[SW_TARGET] = lnk.target;
        lnk.next_word[SW_LIMIT] = lnk.int_limit;
        lnk.next_word[SW_STOP_KEY] = lnk.stop_key;
        lnk.next_word[SW_DIRECTION] = lnk.dir_rev;
    end
endmodule
`default_nettype wire

// file: rtl/dss_supply_timer.sv
// Millisecond supply-wait timer with a cycle divider producing tick pulses.
`timescale 1ns/1ps
`default_nettype none
module dss_supply_timer
#(
    parameter int TICK_CYC = dss_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link to core
    dss_link_if.timer lnk
);
    import dss_pkg::*;
    if (TICK_CYC < 1)
    begin
        $error("TICK_CYC must be at least one cycle.");
    end
    logic [31:0] div;
    logic tick;
    logic [TIMEOUT_WIDTH-1:0] ms_count;
    assign tick = (div == 32'(TICK_CYC - 1));
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div <= 32'h00000000;
        end
        else if (!lnk.timer_run || tick)
        begin
            div <= 32'h00000000;
        end
        else
        begin
            div <= div + 32'h00000001;
        end
    end
    // The count saturates so a long wait cannot wrap past the limit.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ms_count <= '0;
        end
        else if (!lnk.timer_run)
        begin
            ms_count <= '0;
        end
        else if (tick && !lnk.expired)
        begin
            ms_count <= ms_count + 1'b1;
        end
    end
    assign lnk.expired = lnk.timer_run && (ms_count >= lnk.timeout_ms);
endmodule
`default_nettype wire

// file: test/dss_ctl_model.sv
// Behavioural fieldbus controller model that issues drive commands.
`timescale 1ns/1ps
`default_nettype none
module dss_ctl_model
(
    // Clock
    input wire logic i_clk,
    // Drive status
    input wire logic [15:0] i_status,
    // Command
    output logic [15:0] o_ctrl
);
    import dss_pkg::*;
    initial o_ctrl = 16'h0000;
    task automatic send(input logic [15:0] w);
        @(negedge i_clk);
        o_ctrl = w;
    endtask
    // The wait is bounded so that a stuck drive cannot hang the run.
    task automatic bring_up(output logic ok);
        int n;
        send(16'h0006);
        n = 0;
        while ((i_status & STATE_MASK) !== MASKED_READY && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        ok = (n < 100);
        send(16'h000F);
    endtask
endmodule
`default_nettype wire

// file: test/test_drive_state_status_sequencer.sv
// Self-checking bench for the drive state status sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_drive_state_status_sequencer;
    import dss_pkg::*;
    logic clk, rst, rs, init, pwr, fdet, frd, ok;
    logic [1:0] tsel, mode, tact;
    logic [15:0] tmo, ctrl, sw;
    logic [5:0] misc;
    logic [2:0] st;
    logic await_s, cfault, cclose;
    logic [19:0] lfsr;
    int mismatches, comparisons;
    dss_status_sequencer #(.TICK_CYC(4)) dut (.I_CLK(clk), .I_RST(rst),
        .I_CTRL_WORD(ctrl), .I_RESTART(rs), .I_TELEGRAM_SEL(tsel),
        .I_SUPPLY_MODE(mode), .I_SUPPLY_WAIT_TIMEOUT(tmo),
        .I_INIT_DONE(init), .I_POWER_PRESENT(pwr), .I_FAULT_DETECT(fdet),
        .I_FAULT_REACTION_DONE(frd), .I_QSTOP_DONE(1'b0),
        .I_WARNING(misc[5]), .I_DIRECTION_REV(misc[4]),
        .I_STOP_KEY(misc[3]), .I_INTERNAL_LIMIT(misc[2]),
        .I_TARGET_REACHED(misc[1]), .I_REMOTE(misc[0]),
        .O_STATUS_WORD(sw), .O_STATE(st),
        .O_AWAITING_SUPPLY_INDICATION(await_s),
        .O_CONTACTOR_SUPPLY_FAULT(cfault), .O_CONTACTOR_CLOSE(cclose),
        .O_TELEGRAM_ACTIVE(tact));
    dss_ctl_model ctl (.i_clk(clk), .i_status(sw), .o_ctrl(ctrl));
    function automatic logic [19:0] nx(input logic [19:0] v);
        return {v[18:0], v[19] ^ v[16]};
    endfunction
    // Upper byte and warning bit expected from the condition inputs.
    function automatic logic [15:0] hi(input logic [5:0] m);
        return {m[4], m[3], 2'h0, m[2], m[1], m[0], 1'b0, m[5], 7'h00};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Status lags the state by one edge, so two edges are let pass.
    task automatic wt(input dss_state_e s);
        int n;
        n = 0;
        while (st !== s && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check(16'(st), 16'(s));
        repeat (2) @(negedge clk);
    endtask
    task automatic go(input logic [15:0] w, input dss_state_e s);
        ctl.send(w);
        wt(s);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
    initial
    begin
        {rs, init, pwr, fdet, frd} = 5'h00;
        rst = 1'b1;
        tsel = 2'h1;
        mode = MODE_COMBINED;
        tmo = 16'h0002;
        misc = 6'h00;
        lfsr = 20'h184E2;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check(sw, STATUS_RESET);
        @(negedge clk);
        tsel = 2'h2;
        init = 1'b1;
        wt(ST_SW_ON_DIS);
        check(sw & STATE_MASK, MASKED_SW_ON_DIS);
        check(16'(tact), 16'h0001);
        pwr = 1'b1;
        ctl.bring_up(ok);
        check(16'(ok), 16'h0001);
        wt(ST_OP_ENABLED);
        check(sw & STATE_MASK, MASKED_OP_ENABLED);
        repeat (12)
        begin
            lfsr = nx(lfsr);
            misc = lfsr[5:0];
            repeat (2) @(negedge clk);
            check(sw & 16'hFF90, hi(misc) | 16'h0010);
        end
        go(16'h000B, ST_QSTOP);
        check(sw & STATE_MASK, MASKED_QSTOP);
        fdet = 1'b1;
        wt(ST_FAULT_REACT);
        check(sw & STATE_MASK, MASKED_FAULT_REACT);
        frd = 1'b1;
        wt(ST_FAULT);
        check(sw & STATE_MASK, MASKED_FAULT_QS);
        {fdet, frd} = 2'h0;
        ctl.send(16'h0000);
        go(16'h0080, ST_SW_ON_DIS);
        mode = MODE_SEPARATE;
        pwr = 1'b0;
        go(16'h0006, ST_READY);
        check(sw & READY_MASK, READY_NO_SUPPLY);
        check(16'(await_s), 16'h0001);
        pwr = 1'b1;
        repeat (2) @(negedge clk);
        check(sw & READY_MASK, READY_SUPPLY);
        pwr = 1'b0;
        go(16'h0007, ST_SWITCHED_ON);
        check(16'(cfault), 16'h0000);
        wt(ST_FAULT_REACT);
        check(16'(cfault), 16'h0001);
        frd = 1'b1;
        wt(ST_FAULT);
        check(sw & STATE_MASK, MASKED_FAULT);
        frd = 1'b0;
        ctl.send(16'h0000);
        go(16'h0080, ST_SW_ON_DIS);
        mode = MODE_CONTACTOR;
        go(16'h0006, ST_READY);
        check(16'(cclose), 16'h0000);
        pwr = 1'b1;
        go(16'h0007, ST_SWITCHED_ON);
        check(16'(cclose), 16'h0001);
        go(16'h000F, ST_OP_ENABLED);
        check(sw & STATE_MASK, MASKED_OP_ENABLED);
        check(16'(cclose), 16'h0001);
        init = 1'b0;
        rs = 1'b1;
        @(negedge clk) rs = 1'b0;
        wt(ST_NOT_READY);
        check(sw & 16'h004F, 16'h0000);
        check(16'(tact), 16'h0002);
        conclude();
    end
endmodule
`default_nettype wire
